// [logic/osr_pkg.sv]
// Package: constants, types and command set of the overlay host controller
package osr_pkg;
   localparam int ADDR_W = 26;
   localparam int DATA_W = 16;
   // Status word bit positions
   localparam int SB_READY   = 7;
   localparam int SB_ERS_SUS = 6;
   localparam int SB_ERS_ERR = 5;
   localparam int SB_PGM_ERR = 4;
   localparam int SB_BUF_ABT = 3;
   localparam int SB_PGM_SUS = 2;
   localparam int SB_LOCKED  = 1;
   // Defined status bits; 15:8 and 0 are masked away
   localparam logic [15:0] STATUS_MASK = 16'h00fe;
   // Host register offsets (word index on the plain port)
   localparam logic [3:0] REG_CMD    = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h1;
   localparam logic [3:0] REG_WDATA  = 4'h2;
   localparam logic [3:0] REG_RDATA  = 4'h3;
   localparam logic [3:0] REG_STATE  = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;
   // Bus timing: flash access figures in ns and cycles at 4 ns
   localparam int CLK_NS   = 4;
   localparam int T_ACC_NS = 100;
   localparam int T_WP_NS  = 35;
   localparam int T_WPH_NS = 20;
   localparam logic [7:0] ACC_CYC =
      8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + 1);
   localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
   // Bus cycle encodings
   localparam logic [15:0] UNLOCK_A1 = 16'h0555;
   localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
   localparam logic [15:0] UNLOCK_A2 = 16'h02aa;
   localparam logic [15:0] UNLOCK_D2 = 16'h0055;
   // Host-level orders written to REG_CMD; command codes are parameters
   typedef enum logic [3:0] {
      OP_ENTER     = 4'h1,
      OP_EXIT      = 4'h2,
      OP_SW_RESET  = 4'h3,
      OP_PROGRAM   = 4'h4,
      OP_READ      = 4'h5,
      OP_STAT_READ = 4'h6,
      OP_STAT_CLR  = 4'h7,
      OP_ERASE_ALL = 4'h8,
      OP_UNLOCK    = 4'h9,
      OP_CLEAR_BIT = 4'ha
   } osr_op_t;
   // Overlay map the device is believed to show
   typedef enum logic [2:0] {
      MAP_ARRAY = 3'h0,
      MAP_LOCK  = 3'h1,
      MAP_PASS  = 3'h2,
      MAP_PPB   = 3'h3,
      MAP_PLOCK = 3'h4,
      MAP_DYN   = 3'h5,
      MAP_ECC   = 3'h6,
      MAP_CFI   = 3'h7
   } osr_map_t;
   // Bus engine states, Gray in listed order; SETUP to RLOW flips all three bits
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_WLOW  = 3'b011,
      ST_WHIGH = 3'b010,
      ST_RLOW  = 3'b110,
      ST_RHOLD = 3'b111
   } osr_state_t;
   // One flash bus cycle
   typedef struct packed {
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } osr_cycle_t;
   // Flash pin bundle
   typedef struct packed {
      logic              ce_b;
      logic              oe_b;
      logic              we_b;
      logic [ADDR_W-1:0] addr;
   } osr_pins_t;
endpackage : osr_pkg

// [logic/osr_host.sv]
// Host controller driving the flash overlay and status register commands
// Operation
// - Enter protection overlays only from array read
// - Program lock register; exit by either command
// - Software reset leaves overlays, clears timeout
// - Mask reserved status bits 15:8 and 0
// - Result bits meaningful only when ready
`timescale 1ns/1ns
`default_nettype none
module osr_host
   import osr_pkg::*;
#(
   parameter logic [15:0] CMD_SR_READ   = 16'h0070,
   parameter logic [15:0] CMD_SR_CLEAR  = 16'h0071,
   parameter logic [15:0] CMD_RESET     = 16'h00f0,
   parameter logic [15:0] CMD_EXIT1     = 16'h0090,
   parameter logic [15:0] CMD_EXIT2     = 16'h0000,
   parameter logic [15:0] CMD_PROGRAM   = 16'h00a0,
   parameter logic [15:0] CMD_ERASE_ALL = 16'h0080,
   parameter logic [15:0] CMD_ERASE_GO  = 16'h0030,
   parameter logic [15:0] CMD_UNLOCK    = 16'h0029,
   parameter logic [15:0] CMD_CLEAR_BIT = 16'h0000
)(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_b,
   // Software register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // Flash pins
   output logic                   ce_b,
   output logic                   oe_b,
   output logic                   we_b,
   output logic      [ADDR_W-1:0] flash_addr,
   input  wire logic [DATA_W-1:0] dq_in,
   output logic      [DATA_W-1:0] dq_out,
   output logic                   dq_oe,
   input  wire logic              ready_busy_pin
);
   osr_state_t        state_q;
   osr_map_t          map_q;
   osr_map_t          prev_map_q;
   osr_cycle_t        seq_q [0:5];
   logic [2:0]        seq_len_q;
   logic [2:0]        seq_idx_q;
   logic [7:0]        tmr_q;
   logic [ADDR_W-1:0] arg_addr_q;
   logic [DATA_W-1:0] arg_data_q;
   logic [2:0]        arg_map_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] status_q;
   logic              in_status_q;
   logic              refused_q;
   logic [2:0]        rb_sync_q;
   logic              rb_ready_q;
   logic              busy;
   logic              cmd_go;
   logic              reset_ok;

   // Ready pin is asynchronous: three stages, agree on last two
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         rb_sync_q <= 3'h7;
      else
         rb_sync_q <= {rb_sync_q[1:0], ready_busy_pin};
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         rb_ready_q <= 1'b1;
      else if (rb_sync_q[2] == rb_sync_q[1])
         rb_ready_q <= rb_sync_q[2];
   end

   assign busy   = (state_q != ST_IDLE);
   assign cmd_go = reg_wr && (reg_addr == REG_CMD) && !busy;
   // Reset is pointless while an algorithm runs, so refuse it
   assign reset_ok = rb_ready_q;

   // Argument registers
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         arg_addr_q <= '0;
         arg_data_q <= '0;
         arg_map_q  <= 3'h0;
      end
      else if (reg_wr && reg_addr == REG_ADDR)
         arg_addr_q <= reg_wdata[ADDR_W-1:0];
      else if (reg_wr && reg_addr == REG_WDATA)
      begin
         arg_data_q <= reg_wdata[DATA_W-1:0];
         arg_map_q  <= reg_wdata[18:16];
      end
   end

   // Build the bus cycle list for an order
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         seq_len_q <= 3'h0;
         refused_q <= 1'b0;
         for (int i = 0; i < 6; i++)
            seq_q[i] <= '0;
      end
      else if (cmd_go)
      begin
         refused_q <= 1'b0;
         seq_q[0]  <= '{1'b0, ADDR_W'(UNLOCK_A1), UNLOCK_D1};
         seq_q[1]  <= '{1'b0, ADDR_W'(UNLOCK_A2), UNLOCK_D2};
         case (osr_op_t'(reg_wdata[3:0]))
            OP_ENTER:
            begin
               // Entry needs no sector address
               seq_q[2]  <= '{1'b0, ADDR_W'(UNLOCK_A1), {8'h00,
                              5'h00, arg_map_q}};
               seq_len_q <= 3'h3;
               refused_q <= (map_q != MAP_ARRAY);
            end
            OP_EXIT:
            begin
               // Two-cycle common exit works for every overlay
               seq_q[0]  <= '{1'b0, '0, CMD_EXIT1};
               seq_q[1]  <= '{1'b0, '0, CMD_EXIT2};
               seq_len_q <= 3'h2;
            end
            OP_SW_RESET:
            begin
               seq_q[0]  <= '{1'b0, '0, CMD_RESET};
               seq_len_q <= 3'h1;
               refused_q <= !reset_ok;
            end
            OP_PROGRAM, OP_CLEAR_BIT:
            begin
               // Modified word program in an overlay
               seq_q[0]  <= '{1'b0, '0, (reg_wdata[3:0] == OP_PROGRAM) ?
                              CMD_PROGRAM : CMD_CLEAR_BIT};
               seq_q[1]  <= '{1'b0, arg_addr_q, arg_data_q};
               seq_len_q <= 3'h2;
            end
            OP_ERASE_ALL:
            begin
               seq_q[0]  <= '{1'b0, '0, CMD_ERASE_ALL};
               seq_q[1]  <= '{1'b0, '0, CMD_ERASE_GO};
               seq_len_q <= 3'h2;
               refused_q <= (map_q != MAP_PPB);
            end
            OP_UNLOCK:
            begin
               // Unlock command then password word 0
               seq_q[0]  <= '{1'b0, '0, CMD_UNLOCK};
               seq_q[1]  <= '{1'b0, ADDR_W'(0), arg_data_q};
               seq_len_q <= 3'h2;
               refused_q <= (map_q != MAP_PASS);
            end
            OP_READ:
            begin
               // Word 0 lock reg, 0..3 password, sector bit 0
               seq_q[0]  <= '{1'b1, arg_addr_q, '0};
               seq_len_q <= 3'h1;
            end
            OP_STAT_READ:
            begin
               // Command write then one read ends overlay
               seq_q[0]  <= '{1'b0, ADDR_W'(UNLOCK_A1), CMD_SR_READ};
               seq_q[1]  <= '{1'b1, '0, '0};
               seq_len_q <= 3'h2;
            end
            OP_STAT_CLR:
            begin
               seq_q[0]  <= '{1'b0, ADDR_W'(UNLOCK_A1), CMD_SR_CLEAR};
               seq_len_q <= 3'h1;
            end
            default:
            begin
               seq_len_q <= 3'h0;
               refused_q <= 1'b1;
            end
         endcase
      end
   end

   // Bus cycle engine with strobe timing
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state_q   <= ST_IDLE;
         seq_idx_q <= 3'h0;
         tmr_q     <= 8'h00;
      end
      else
         case (state_q)
            ST_IDLE:
               if (cmd_go)
                  state_q <= ST_SETUP;
            ST_SETUP:
            begin
               tmr_q <= 8'h00;
               if (refused_q || seq_idx_q == seq_len_q)
               begin
                  state_q   <= ST_IDLE;
                  seq_idx_q <= 3'h0;
               end
               else
                  state_q <= seq_q[seq_idx_q].rd ? ST_RLOW : ST_WLOW;
            end
            ST_WLOW:
               if (tmr_q == WP_CYC)
               begin
                  state_q <= ST_WHIGH;
                  tmr_q   <= 8'h00;
               end
               else
                  tmr_q <= tmr_q + 8'h01;
            ST_WHIGH, ST_RHOLD:
               if (tmr_q == WPH_CYC)
               begin
                  state_q   <= ST_SETUP;
                  seq_idx_q <= seq_idx_q + 3'h1;
               end
               else
                  tmr_q <= tmr_q + 8'h01;
            ST_RLOW:
               if (tmr_q == ACC_CYC)
               begin
                  state_q <= ST_RHOLD;
                  tmr_q   <= 8'h00;
               end
               else
                  tmr_q <= tmr_q + 8'h01;
            default:
               state_q <= ST_IDLE;
         endcase
   end

   // Pins straight from flops; data driven only in write cycles
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ce_b       <= 1'b1;
         oe_b       <= 1'b1;
         we_b       <= 1'b1;
         dq_oe      <= 1'b0;
         dq_out     <= '0;
         flash_addr <= '0;
      end
      else
      begin
         ce_b  <= !(state_q == ST_WLOW || state_q == ST_RLOW);
         oe_b  <= (state_q != ST_RLOW);
         we_b  <= (state_q != ST_WLOW);
         dq_oe <= (state_q == ST_WLOW || state_q == ST_WHIGH);
         if (state_q == ST_SETUP && seq_idx_q != seq_len_q)
         begin
            flash_addr <= seq_q[seq_idx_q].addr;
            dq_out     <= seq_q[seq_idx_q].data;
         end
      end
   end

   // Read capture at end of access; status word masked
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         rdata_q  <= '0;
         status_q <= 16'h0080; // Ready, nothing pending
      end
      else if (state_q == ST_RLOW && tmr_q == ACC_CYC)
      begin
         if (in_status_q)
         begin
            if (dq_in[SB_READY])
               status_q <= dq_in & STATUS_MASK;
            else
               status_q <= 16'h0000;
         end
         else
            rdata_q <= dq_in;
      end
   end

   // Tracked overlay map; status overlay restores prior map
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         map_q       <= MAP_ARRAY;
         prev_map_q  <= MAP_ARRAY;
         in_status_q <= 1'b0;
      end
      else if (cmd_go)
      begin
         case (osr_op_t'(reg_wdata[3:0]))
            OP_ENTER:
               if (map_q == MAP_ARRAY)
                  map_q <= osr_map_t'(arg_map_q);
            OP_EXIT:
               map_q <= MAP_ARRAY;
            OP_SW_RESET:
               if (reset_ok)
                  map_q <= MAP_ARRAY;
            OP_STAT_READ:
            begin
               prev_map_q  <= map_q;
               in_status_q <= 1'b1;
            end
            default:
               map_q <= map_q;
         endcase
      end
      else if (in_status_q && state_q == ST_RHOLD && tmr_q == WPH_CYC)
      begin
         in_status_q <= 1'b0;
         map_q       <= prev_map_q;
      end
   end

   // Register read port, data one cycle after strobe
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         reg_rdata <= '0;
      else if (reg_rd)
         case (reg_addr)
            REG_ADDR:   reg_rdata <= 32'(arg_addr_q);
            REG_WDATA:  reg_rdata <= {13'h0000, arg_map_q, arg_data_q};
            REG_RDATA:  reg_rdata <= {16'h0000, rdata_q};
            REG_STATE:  reg_rdata <= {25'h0000000, refused_q, rb_ready_q,
                                      busy, 1'b0, map_q};
            REG_STATUS: reg_rdata <= {16'h0000, status_q};
            default:    reg_rdata <= 32'h00000000;
         endcase
      else
         reg_rdata <= 32'h00000000;
   end
endmodule // osr_host
`default_nettype wire

// [verif/osr_host_assertions.sv]
// Checker: flash strobe and register port properties of the host
`timescale 1ns/1ns
`default_nettype none
module osr_host_assertions
   import osr_pkg::*;
(
   // Clock, reset and register port
   input wire logic              mclk,
   input wire logic              rst_b,
   input wire logic [3:0]        reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   // Flash pins
   input wire logic              ce_b,
   input wire logic              oe_b,
   input wire logic              we_b,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic              dq_oe,
   input wire logic              ready_busy_pin
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Orders only count while the chip enable pin is high
   wire logic cmd_wr = reg_wr && reg_addr == REG_CMD && ce_b;
   property p_rst_idle;
      $rose(rst_b) |-> ce_b && oe_b && we_b && !dq_oe && reg_rdata == 32'h0;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("pins not idle");
   property p_rdata_zero;
      !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   a_rdata_zero: assert property (p_rdata_zero) else $error("stray rdata");
   property p_no_fight;
      !oe_b |-> !dq_oe && we_b;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus fight");
   property p_we_drive;
      !we_b |-> dq_oe && !ce_b && oe_b;
   endproperty
   a_we_drive: assert property (p_we_drive) else $error("write undriven");
   property p_we_width;
      $fell(we_b) |-> !we_b [*8];
   endproperty
   a_we_width: assert property (p_we_width) else $error("short write");
   property p_we_gap;
      $rose(we_b) |-> we_b [*5];
   endproperty
   a_we_gap: assert property (p_we_gap) else $error("short write gap");
   property p_rd_width;
      $fell(oe_b) |-> (!oe_b && !ce_b) [*8];
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("short read");
   property p_sr_read;
      cmd_wr && reg_wdata[3:0] == OP_STAT_READ |-> ##[1:200] $fell(oe_b);
   endproperty
   a_sr_read: assert property (p_sr_read) else $error("no status read");
   property p_rst_refused;
      cmd_wr && reg_wdata[3:0] == OP_SW_RESET && !ready_busy_pin &&
         !$past(ready_busy_pin, 3) &&
         !$past(ready_busy_pin, 4) |=> ce_b [*8];
   endproperty
   a_rst_refused: assert property (p_rst_refused) else $error("reset sent");
   c_sr: cover property (cmd_wr && reg_wdata[3:0] == OP_STAT_READ);
   c_rst: cover property (cmd_wr && reg_wdata[3:0] == OP_SW_RESET);
   c_ent: cover property (cmd_wr && reg_wdata[3:0] == OP_ENTER);
endmodule // osr_host_assertions
bind osr_host osr_host_assertions i_chk (.mclk(mclk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ce_b(ce_b), .oe_b(oe_b),
   .we_b(we_b), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out),
   .dq_oe(dq_oe), .ready_busy_pin(ready_busy_pin));
`default_nettype wire

// [verif/osr_flash_model.sv]
// Flash model: status register overlay, clear and reset commands
`timescale 1ns/1ns
`default_nettype none
module osr_flash_model
   import osr_pkg::*;
(
   // Flash pins
   input  wire logic              ce_b,
   input  wire logic              oe_b,
   input  wire logic              we_b,
   input  wire logic [ADDR_W-1:0] flash_addr,
   input  wire logic [DATA_W-1:0] host_dq,
   input  wire logic              host_oe,
   output logic      [DATA_W-1:0] dq,
   output logic                   ready_busy_pin,
   // Test controls
   input  wire logic              busy,
   input  wire logic              inject,
   input  wire logic [7:0]        fail_bits
);
   logic [7:0]  res_q = 8'h00; // All clear at power-up
   logic [15:0] word_q = 16'h0000;
   logic [15:0] last_q = 16'h0000;
   logic [15:0] cmd_w = 16'h0000;
   logic [7:0]  rsv_q = 8'h00;
   logic        stat_q = 1'b0;
   logic [2:0]  ovl_q = 3'h0;
   logic        unl_q = 1'b0;
   // Arbitrary lock word and resume codes, only matched by the bench
   localparam logic [15:0] LOCK_WORD  = 16'hc3a5;
   localparam logic [15:0] RESUME_ERS = 16'h00e1;
   localparam logic [15:0] RESUME_PGM = 16'h00e2;
   wire logic   rd_act = !ce_b && !oe_b;
   assign ready_busy_pin = !busy;
   // Released bus shows the inverse of the last read, never a held value
   always @*
      if (rd_act && stat_q)
         dq = {rsv_q, word_q[7:1], rsv_q[0]};
      else if (rd_act && ovl_q == 3'h1 && flash_addr == '0)
         dq = LOCK_WORD;
      else if (rd_act && ovl_q == 3'h4)
         dq = {flash_addr[15:1], 1'b1};
      else if (rd_act)
         dq = flash_addr[15:0] ^ 16'h5a5a;
      else if (host_oe)
         dq = host_dq;
      else
         dq = ~last_q;
   // Data follows the host bus while the write strobe is low, held after it rises
   always @*
      if (!we_b)
         cmd_w = host_dq;
   // First completed read leaves the overlay, reserved bits wander
   always @(negedge rd_act)
   begin
      stat_q <= 1'b0;
      last_q <= dq;
      rsv_q  <= rsv_q + 8'h01;
   end
   // Overlay code follows the two unlock cycles; exit or reset leaves it
   always @(posedge we_b)
   begin
      unl_q <= (cmd_w == UNLOCK_D2);
      if (cmd_w == 16'h0090 || cmd_w == 16'h00f0)
         ovl_q <= 3'h0;
      else if (unl_q && cmd_w[15:3] == 13'h0000)
         ovl_q <= cmd_w[2:0];
   end
   // Failed algorithm results set from the bench
   always @(posedge inject)
      res_q <= res_q | fail_bits;
   // Commands take effect on the rising write strobe
   always @(posedge we_b)
      if (cmd_w == 16'h0070)
      begin
         word_q <= {8'h00, !busy, res_q[6:1], 1'b0};
         stat_q <= 1'b1;
      end
      else if (cmd_w == 16'h0071)
         res_q <= res_q & 8'h44;
      else if (cmd_w == 16'h00f0 && !busy)
      begin
         stat_q <= 1'b0;
         if (!res_q[3])
            res_q <= res_q & 8'hcc;
      end
      else if (cmd_w == RESUME_ERS)
         res_q[6] <= 1'b0;
      else if (cmd_w == RESUME_PGM)
         res_q[2] <= 1'b0;
endmodule // osr_flash_model
`default_nettype wire

// [verif/testbench.sv]
// Testbench: register-level tests of the overlay host controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import osr_pkg::*;
   logic              mclk = 1'b0;
   logic              rst_b = 1'b0;
   logic [3:0]        reg_addr = 4'h0;
   logic [31:0]       reg_wdata = 32'h0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic              busy = 1'b0;
   logic              inject = 1'b0;
   logic [7:0]        fail_bits = 8'h00;
   logic [31:0]       reg_rdata, d;
   logic              ce_b, oe_b, we_b, dq_oe, rdy;
   logic [ADDR_W-1:0] faddr;
   logic [DATA_W-1:0] dq_host, dq_bus;
   logic [3:0]        ops [4] = '{OP_PROGRAM, OP_UNLOCK, OP_ERASE_ALL, OP_CLEAR_BIT};
   logic [2:0]        maps [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
   int                fails = 0;
   int                check_count = 0;
   always #2 mclk = ~mclk;
   osr_host i_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
      .flash_addr(faddr), .dq_in(dq_bus), .dq_out(dq_host), .dq_oe(dq_oe),
      .ready_busy_pin(rdy));
   osr_flash_model i_flash (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
      .flash_addr(faddr), .host_dq(dq_host), .host_oe(dq_oe), .dq(dq_bus),
      .ready_busy_pin(rdy), .busy(busy), .inject(inject),
      .fail_bits(fail_bits));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Order, then poll busy under a bound; refusals raise it for the SETUP cycle only
   task op(input logic [3:0] o, input logic [31:0] w);
      int n;
      n = 0;
      wr(REG_WDATA, w);
      wr(REG_CMD, {28'h0, o});
      repeat (2) @(posedge mclk);
      rd(REG_STATE);
      while (d[4] !== 1'b0 && n < 200)
      begin
         rd(REG_STATE);
         n++;
      end
      // A bus engine that never goes idle counts as a mismatch
      if (d[4] !== 1'b0)
         fails++;
   endtask
   task sr(input logic [31:0] exp);
      op(OP_STAT_READ, 32'h0);
      rd(REG_STATUS);
      check(d, exp);
   endtask
   task hit(input logic [7:0] b);
      @(posedge mclk);
      fail_bits <= b;
      inject    <= 1'b1;
      @(posedge mclk);
      inject    <= 1'b0;
   endtask
   task results;
      if (fails == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      sr(32'h80);
      rd(4'hf);
      hit(8'h3a);
      sr(32'hba);
      wr(REG_ADDR, 32'h10);
      op(OP_READ, 32'h0);
      rd(REG_RDATA);
      check(d, 32'h5a4a);
      op(OP_SW_RESET, 32'h0);
      sr(32'hba);
      hit(8'h44);
      op(OP_STAT_CLR, 32'h0);
      sr(32'hc4);
      hit(8'h32);
      op(OP_SW_RESET, 32'h0);
      sr(32'hc4);
      op(OP_PROGRAM, 32'he1);
      sr(32'h84);
      op(OP_PROGRAM, 32'he2);
      sr(32'h80);
      busy <= 1'b1;
      repeat (8) @(posedge mclk);
      op(OP_SW_RESET, 32'h0);
      rd(REG_STATE);
      check(d, 32'h40);
      sr(32'h0);
      busy <= 1'b0;
      repeat (8) @(posedge mclk);
      for (int c = 1; c < 7; c++)
      begin
         op(OP_ENTER, 32'(c) << 16);
         rd(REG_STATE);
         check(d, 32'h20 | 32'(c));
         op(OP_EXIT, 32'h0);
         rd(REG_STATE);
         check(d, 32'h20);
      end
      // Lock word at location zero, global lock bit anywhere
      op(OP_ENTER, 32'h1 << 16);
      wr(REG_ADDR, 32'h0);
      op(OP_READ, 32'h0);
      rd(REG_RDATA);
      check(d, 32'hc3a5);
      op(OP_EXIT, 32'h0);
      op(OP_ENTER, 32'h4 << 16);
      wr(REG_ADDR, 32'h10);
      op(OP_READ, 32'h0);
      rd(REG_RDATA);
      check(d, 32'h11);
      op(OP_EXIT, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         op(OP_ENTER, {13'h0, maps[i], 16'h0});
         op(ops[i], 32'h1);
         rd(REG_STATE);
         check(d, {25'h0, 4'h4, maps[i]});
         op(OP_ENTER, 32'h2 << 16);
         op(OP_UNLOCK - 4'(i & 1), 32'h0);
         rd(REG_STATE);
         check(d, {25'h0, 4'hc, maps[i]});
         op(OP_EXIT, 32'h0);
      end
      op(OP_ENTER, 32'h7 << 16);
      op(OP_SW_RESET, 32'h0);
      rd(REG_STATE);
      check(d, 32'h20);
      // Undecoded order is refused without pin activity
      op(4'hb, 32'h0);
      rd(REG_STATE);
      check(d, 32'h60);
      // Mid-run reset brings the status copy back to ready
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      rd(REG_STATUS);
      check(d, 32'h80);
      rd(REG_STATE);
      check(d, 32'h20);
      results();
   end
   // Watchdog well beyond the expected run
   initial
   begin
      #300000;
      fails++;
      results();
   end
endmodule // testbench
`default_nettype wire
